/* File: rtl/osc_stab_cfg.svh */
/*
  Register offsets, reset values and threshold exponents for the
  oscillation stabilization counter and peripheral clock gate.
  Assumes inclusion by bare name from the package and the bench.
*/
// Functional notes
// - Status clears on reset, on the STOP instruction, and while the stop bit is 1.
// - Counting starts on crystal oscillator start, and on STOP mode release.
// - Flags set one at a time from the lowest and stay set until cleared.
// - Status bits 7 to 0 mark 2^8,9,10,11,13,15,17,18 crystal cycles elapsed.
// - A 3-bit select code 0 to 7 picks one of those eight stabilization times.
// - After oscillator start, clock use waits until the selected time elapses.
// - Counter stops at the selected time; flags beyond it never set.
// - Only real crystal clock edges advance the count; startup delay excluded.
// - Select register resets to code 7; its upper five bits read zero.
// - Status reads by bit or byte; software writes to it are ignored.
// - Select register takes only whole-byte writes.
// - Peripheral enable register resets to zero; takes bit or byte writes.
// - Enable bits: 7 timer/clock, 5 converter, 4 two-wire, 3/2 serial, 0 timer array.
// - A disabled peripheral has no clock, is held in reset, writes ignored.
// - An enabled peripheral gets its clock and accepts reads and writes.
// - Stop bit 0 runs the crystal oscillator, 1 stops it.
`ifndef OSC_STAB_CFG_SVH
`define OSC_STAB_CFG_SVH

`define ADDR_PERIPH_CLOCK_ENABLE 20'hF00F0
`define ADDR_STAB_COUNT_STATUS 20'hFFFA2
`define ADDR_STAB_TIME_SELECT 20'hFFFA3

`define RST_PERIPH_CLOCK_ENABLE 8'h00
`define RST_STAB_TIME_SELECT 3'h7

`define PER_BIT_RTC 7
`define PER_BIT_CONV 5
`define PER_BIT_TWI 4
`define PER_BIT_SER1 3
`define PER_BIT_SER0 2
`define PER_BIT_TIMER 0
`define PER_WRITABLE_MASK 8'hBD

`define STAB_SHIFT_0 8
`define STAB_SHIFT_1 9
`define STAB_SHIFT_2 10
`define STAB_SHIFT_3 11
`define STAB_SHIFT_4 13
`define STAB_SHIFT_5 15
`define STAB_SHIFT_6 17
`define STAB_SHIFT_7 18
`define STAB_COUNT_WIDTH 19

`endif

/* File: rtl/osc_stab_gate.sv */
/*
  Crystal oscillation stabilization counter with status and select
  registers, plus the peripheral clock enable register and its gating.
  Assumes a 10 MHz system clock, a crystal clock pin slower than half of
  it, and clock-control levels and STOP pulses from the same clock domain.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module osc_stab_gate
  import osc_stab_pkg::*;
#(
  parameter int CNT_W = `STAB_COUNT_WIDTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire reg_req_t req_in,
  output logic [7:0] rd_data_out,
  // Clock control
  input wire logic xtal_clk_in,
  input wire logic hs_osc_stop_in,
  input wire logic hs_osc_mode_select_in,
  input wire logic hs_external_clock_select_in,
  input wire logic stop_exec_in,
  input wire logic stop_release_in,
  output logic osc_ready_out,
  // Peripheral gating
  input wire logic [5:0] periph_wr_in,
  output logic [5:0] periph_clk_en_out,
  output logic [5:0] periph_rst_out,
  output logic [5:0] periph_wr_out
);

  localparam int SHIFTS [8] = '{`STAB_SHIFT_0, `STAB_SHIFT_1, `STAB_SHIFT_2, `STAB_SHIFT_3,
                                `STAB_SHIFT_4, `STAB_SHIFT_5, `STAB_SHIFT_6, `STAB_SHIFT_7};
  localparam int PER_BITS [6] = '{`PER_BIT_TIMER, `PER_BIT_SER0, `PER_BIT_SER1,
                                  `PER_BIT_TWI, `PER_BIT_CONV, `PER_BIT_RTC};
  localparam logic [7:0] PER_MASK = `PER_WRITABLE_MASK;

  if (CNT_W < `STAB_COUNT_WIDTH)
  begin : g_bad_width
    $error("osc_stab_gate: CNT_W cannot hold the longest threshold");
  end

  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic xedge;
  logic stop_prev;
  logic start_evt;
  logic clear_evt;
  logic [2:0] sel;
  logic [7:0] per;
  logic [7:0] flags;
  logic [7:0] status;
  logic [7:0] allow;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] thr_sel;
  logic step;
  cnt_state_t state;
  logic xtal_mode;
  logic sel_wr;
  logic sel_rd;
  logic per_wr;
  logic per_bit_wr;
  logic [7:0] bit_onehot;
  logic [5:0] per_used;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= xtal_clk_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign xedge = sync_b && !sync_c;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      stop_prev <= 1'b1;
    else
      stop_prev <= hs_osc_stop_in;
  end

  assign clear_evt = stop_exec_in || hs_osc_stop_in;

  assign xtal_mode = hs_osc_mode_select_in && !hs_external_clock_select_in;

  assign start_evt = !hs_osc_stop_in && !stop_exec_in && ((stop_prev && xtal_mode) || stop_release_in);

  always_comb
  begin
    thr_sel = '0;
    thr_sel[SHIFTS[sel]] = 1'b1;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      allow[i] = (i <= int'(sel));
  end

  assign step = (state == CNT_RUN) && xedge;
  assign next_count = step ? count + 1'b1 : count;

  always_ff @(posedge clk_in)
  begin
    if (rst_in || start_evt)
      count <= '0;
    else
      count <= next_count;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || clear_evt)
      state <= CNT_IDLE;
    else if (start_evt)
      state <= CNT_RUN;
    else
    begin
      case (state)
        CNT_RUN:
          if (step && next_count >= thr_sel)
            state <= CNT_DONE;
        CNT_IDLE, CNT_DONE:
          state <= state;
        default:
          state <= CNT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || clear_evt || start_evt)
      osc_ready_out <= 1'b0;
    else if (state == CNT_RUN && step && next_count >= thr_sel)
      osc_ready_out <= 1'b1;
  end

  for (genvar g = 0; g < 8; g++)
  begin : g_flag
    stab_flag_cell #(
      .SHIFT(SHIFTS[g]),
      .CNT_W(CNT_W)
    ) u_cell (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(clear_evt),
      .step_in(step),
      .allow_in(allow[g]),
      .next_count_in(next_count),
      .flag_out(flags[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      status[7 - i] = flags[i];
  end

  assign sel_wr = req_in.wr && !req_in.bit_mode && req_in.addr == `ADDR_STAB_TIME_SELECT;
  assign sel_rd = req_in.rd && req_in.addr == `ADDR_STAB_TIME_SELECT;
  assign per_wr = req_in.wr && req_in.addr == `ADDR_PERIPH_CLOCK_ENABLE;
  assign per_bit_wr = per_wr && req_in.bit_mode;
  assign bit_onehot = 8'h01 << req_in.bit_sel;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sel <= `RST_STAB_TIME_SELECT;
    else if (sel_wr)
      sel <= req_in.wdata[2:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      per <= `RST_PERIPH_CLOCK_ENABLE;
    else if (per_wr)
    begin
      if (req_in.bit_mode)
        per[req_in.bit_sel] <= req_in.wdata[req_in.bit_sel] & PER_MASK[req_in.bit_sel];
      else
        per <= req_in.wdata & `PER_WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || !req_in.rd)
      rd_data_out <= 8'h00;
    else
    begin
      case (req_in.addr)
        `ADDR_STAB_COUNT_STATUS:
          rd_data_out <= status;
        `ADDR_STAB_TIME_SELECT:
          rd_data_out <= {5'h00, sel};
        `ADDR_PERIPH_CLOCK_ENABLE:
          rd_data_out <= per;
        default:
          rd_data_out <= 8'h00;
      endcase
    end
  end

  assign per_used = {per[`PER_BIT_RTC], per[`PER_BIT_CONV], per[`PER_BIT_TWI],
                     per[`PER_BIT_SER1], per[`PER_BIT_SER0], per[`PER_BIT_TIMER]};

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      periph_clk_en_out <= 6'h00;
    else
    begin
      for (int i = 0; i < 6; i++)
        periph_clk_en_out[i] <= per[PER_BITS[i]];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      periph_rst_out <= 6'h3F;
    else
    begin
      for (int i = 0; i < 6; i++)
        periph_rst_out[i] <= !per[PER_BITS[i]];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      periph_wr_out <= 6'h00;
    else
    begin
      for (int i = 0; i < 6; i++)
        periph_wr_out[i] <= periph_wr_in[i] && per[PER_BITS[i]];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_status_clear: assert property (clear_evt |=> status == 8'h00)
    else $error("status not cleared");
  a_count_start: assert property (start_evt |=> count == '0 && state == CNT_RUN)
    else $error("counter did not restart");
  a_flag_thermo: assert property (((flags >> 1) & ~flags) == 8'h00)
    else $error("flags not set in order");
  a_flag_sticky: assert property (!clear_evt |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without clear");
  a_first_threshold: assert property ($rose(flags[0]) |-> count == 256)
    else $error("lowest flag at wrong count");
  a_ready_time: assert property ($rose(osc_ready_out) |-> count == $past(thr_sel))
    else $error("ready at wrong count");
  a_flag_cap: assert property (##1 ((flags & ~$past(flags)) & ~$past(allow)) == 8'h00)
    else $error("flag beyond selected time");
  a_count_edges: assert property (!start_evt && !xedge |=> $stable(count))
    else $error("count moved without crystal edge");
  a_select_reset: assert property (disable iff (1'b0) rst_in |=> sel == 3'h7)
    else $error("select reset wrong");
  a_select_byte: assert property (req_in.wr && req_in.bit_mode |=> $stable(sel))
    else $error("bit write changed select");
  a_per_reset: assert property (disable iff (1'b0) rst_in |=> per == 8'h00)
    else $error("enable reset wrong");
  a_periph_gate: assert property (##1 (periph_wr_out & ~periph_clk_en_out) == 6'h00 ##0
                                  periph_rst_out == ~periph_clk_en_out)
    else $error("disabled peripheral not gated");

  // Register checks
  a_status_source: assert property ($changed(status) |-> $past(step) || $past(clear_evt))
    else $error("status changed without count or clear");
  a_select_write: assert property (sel_wr |=> sel == $past(req_in.wdata[2:0]))
    else $error("byte write to select lost");
  a_select_upper: assert property (sel_rd |=> rd_data_out[7:3] == 5'h00)
    else $error("select upper bits not zero");
  a_per_reserved: assert property (per[1] == 1'b0 && per[6] == 1'b0)
    else $error("reserved enable bit set");
  a_per_bit_write: assert property (per_bit_wr |=> ((per ^ $past(per)) & ~$past(bit_onehot)) == 8'h00)
    else $error("bit write touched other bits");

  // Gate checks
  a_periph_enable: assert property (##1 periph_clk_en_out == $past(per_used))
    else $error("clock enable not following enable bit");
  a_wr_pass: assert property (##1 periph_wr_out == ($past(periph_wr_in) & $past(per_used)))
    else $error("enabled write not passed");

  // Counter checks
  a_osc_start: assert property ($fell(hs_osc_stop_in) && xtal_mode && !stop_exec_in |=> state == CNT_RUN)
    else $error("crystal start did not run counter");
  a_release_start: assert property (stop_release_in && !hs_osc_stop_in && !stop_exec_in |=> count == '0)
    else $error("release did not restart counter");
  a_ready_hold: assert property (state == CNT_RUN |-> !osc_ready_out)
    else $error("ready while still counting");
  a_count_held: assert property (state == CNT_DONE && !start_evt |=> $stable(count))
    else $error("count moved after selected time");

  c_ready: cover property ($rose(osc_ready_out));
  c_all_flags: cover property (flags == 8'hFF);
  c_periph_write: cover property (|periph_wr_out);
  c_release_restart: cover property (stop_release_in && state == CNT_IDLE);
  c_bit_write: cover property (per_bit_wr);

endmodule : osc_stab_gate

/* File: rtl/osc_stab_pkg.sv */
/*
  Types for the oscillation stabilization counter and peripheral gate.
  Assumes the constants header sits beside it.
*/
`include "osc_stab_cfg.svh"

package osc_stab_pkg;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic bit_mode;
    logic [2:0] bit_sel;
  } reg_req_t;

  typedef enum logic [1:0] {
    CNT_IDLE,
    CNT_RUN,
    CNT_DONE
  } cnt_state_t;

endpackage : osc_stab_pkg

/* File: rtl/stab_flag_cell.sv */
/*
  One sticky stabilization flag that sets when the count reaches 2^SHIFT.
  Assumes next_count_in and step_in come from the same clock domain.
*/
`timescale 1ns/1ps

module stab_flag_cell #(
  parameter int SHIFT = 8,
  parameter int CNT_W = 19
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic allow_in,
  input wire logic [CNT_W-1:0] next_count_in,
  // Flag
  output logic flag_out
);

  localparam logic [CNT_W-1:0] THRESHOLD = {{(CNT_W-1){1'b0}}, 1'b1} << SHIFT;

  if (SHIFT >= CNT_W)
  begin : g_bad_shift
    $error("stab_flag_cell: SHIFT too large for CNT_W");
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || clear_in)
      flag_out <= 1'b0;
    else if (step_in && allow_in && next_count_in == THRESHOLD)
      flag_out <= 1'b1;
  end

endmodule : stab_flag_cell

/* File: tb/osc_stab_gate_bench.sv */
/*
  Self-checking bench for the stabilization counter and peripheral gate.
  Assumes the package and constants header are compiled first.
*/
`timescale 1ns/1ps
`include "osc_stab_cfg.svh"

module osc_stab_gate_bench;
  import osc_stab_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  reg_req_t req_in = '0;
  logic [7:0] rd_data_out;
  logic xtal_clk_in = 1'b0;
  logic hs_osc_stop_in = 1'b1;
  logic hs_osc_mode_select_in = 1'b1;
  logic hs_external_clock_select_in = 1'b0;
  logic stop_exec_in = 1'b0;
  logic stop_release_in = 1'b0;
  logic osc_ready_out;
  logic [5:0] periph_wr_in = '0;
  logic [5:0] periph_clk_en_out;
  logic [5:0] periph_rst_out;
  logic [5:0] periph_wr_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] seen;

  osc_stab_gate u_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .req_in(req_in),
    .rd_data_out(rd_data_out),
    .xtal_clk_in(xtal_clk_in),
    .hs_osc_stop_in(hs_osc_stop_in),
    .hs_osc_mode_select_in(hs_osc_mode_select_in),
    .hs_external_clock_select_in(hs_external_clock_select_in),
    .stop_exec_in(stop_exec_in),
    .stop_release_in(stop_release_in),
    .osc_ready_out(osc_ready_out),
    .periph_wr_in(periph_wr_in),
    .periph_clk_en_out(periph_clk_en_out),
    .periph_rst_out(periph_rst_out),
    .periph_wr_out(periph_wr_out)
  );

  always #50 clk_in = ~clk_in;

  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Cycle ceiling against a hang
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [19:0] a, input logic [7:0] d, input logic bm, input logic [2:0] bs);
    @(posedge clk_in);
    req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bit_mode: bm, bit_sel: bs};
    @(posedge clk_in);
    req_in.wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_mode: 1'b0, bit_sel: 3'h0};
    @(posedge clk_in);
    req_in.rd <= 1'b0;
    #1;
    d = rd_data_out;
  endtask : reg_read

  task automatic xtal_edges(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk_in);
      xtal_clk_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      xtal_clk_in <= 1'b0;
    end
    repeat (8) @(posedge clk_in);
  endtask : xtal_edges

  task automatic pulse(input int which);
    @(posedge clk_in);
    if (which == 0)
      stop_exec_in <= 1'b1;
    else
      stop_release_in <= 1'b1;
    @(posedge clk_in);
    stop_exec_in <= 1'b0;
    stop_release_in <= 1'b0;
  endtask : pulse

  task automatic status_is(input logic [7:0] exp, input logic rdy);
    reg_read(`ADDR_STAB_COUNT_STATUS, seen);
    check("status", seen, exp);
    check("ready", {7'h00, osc_ready_out}, {7'h00, rdy});
  endtask : status_is

  task automatic reset_values();
    reg_read(`ADDR_PERIPH_CLOCK_ENABLE, seen);
    check("enable reset", seen, `RST_PERIPH_CLOCK_ENABLE);
    reg_read(`ADDR_STAB_TIME_SELECT, seen);
    check("select reset", seen, {5'h00, `RST_STAB_TIME_SELECT});
    reg_read(`ADDR_STAB_COUNT_STATUS, seen);
    check("status reset", seen, 8'h00);
    reg_read(20'h00000, seen);
    check("unmapped", seen, 8'h00);
    check("rst at reset", {2'b00, periph_rst_out}, 8'h3F);
  endtask : reset_values

  task automatic gate_test();
    @(posedge clk_in);
    periph_wr_in <= 6'h3F;
    @(posedge clk_in);
    periph_wr_in <= 6'h00;
    #1;
    check("wr while off", {2'b00, periph_wr_out}, 8'h00);
    reg_write(`ADDR_PERIPH_CLOCK_ENABLE, `PER_WRITABLE_MASK, 1'b0, 3'h0);
    reg_read(`ADDR_PERIPH_CLOCK_ENABLE, seen);
    check("enable all", seen, `PER_WRITABLE_MASK);
    reg_write(`ADDR_PERIPH_CLOCK_ENABLE, 8'h05, 1'b0, 3'h0);
    reg_write(`ADDR_PERIPH_CLOCK_ENABLE, 8'h80, 1'b1, 3'h7);
    reg_write(`ADDR_PERIPH_CLOCK_ENABLE, 8'h00, 1'b1, 3'h6);
    reg_read(`ADDR_PERIPH_CLOCK_ENABLE, seen);
    check("enable bits", seen, 8'h85);
    check("clk en", {2'b00, periph_clk_en_out}, 8'h23);
    check("rst", {2'b00, periph_rst_out}, 8'h1C);
    @(posedge clk_in);
    periph_wr_in <= 6'h3F;
    @(posedge clk_in);
    periph_wr_in <= 6'h00;
    #1;
    check("wr gated", {2'b00, periph_wr_out}, 8'h23);
  endtask : gate_test

  task automatic select_test();
    reg_write(`ADDR_STAB_TIME_SELECT, 8'h00, 1'b1, 3'h0);
    reg_read(`ADDR_STAB_TIME_SELECT, seen);
    check("select bit write", seen, 8'h07);
    reg_write(`ADDR_STAB_TIME_SELECT, 8'hF8, 1'b0, 3'h0);
    reg_read(`ADDR_STAB_TIME_SELECT, seen);
    check("select byte write", seen, 8'h00);
  endtask : select_test

  task automatic count_shortest();
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b0;
    xtal_edges(255);
    status_is(8'h00, 1'b0);
    xtal_edges(1);
    status_is(8'h80, 1'b1);
    xtal_edges(300);
    reg_write(`ADDR_STAB_COUNT_STATUS, 8'hFF, 1'b0, 3'h0);
    status_is(8'h80, 1'b1);
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b1;
    status_is(8'h00, 1'b0);
  endtask : count_shortest

  task automatic count_stop_release();
    reg_write(`ADDR_STAB_TIME_SELECT, 8'h01, 1'b0, 3'h0);
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b0;
    xtal_edges(512);
    status_is(8'hC0, 1'b1);
    pulse(0);
    reg_read(`ADDR_STAB_COUNT_STATUS, seen);
    check("status after stop", seen, 8'h00);
    pulse(1);
    xtal_edges(256);
    status_is(8'h80, 1'b0);
    xtal_edges(256);
    status_is(8'hC0, 1'b1);
  endtask : count_stop_release

  task automatic mode_test();
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b1;
    hs_external_clock_select_in <= 1'b1;
    status_is(8'h00, 1'b0);
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b0;
    xtal_edges(257);
    status_is(8'h00, 1'b0);
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b1;
    hs_external_clock_select_in <= 1'b0;
    hs_osc_mode_select_in <= 1'b0;
    @(posedge clk_in);
    hs_osc_stop_in <= 1'b0;
    xtal_edges(257);
    status_is(8'h00, 1'b0);
    @(posedge clk_in);
    hs_osc_mode_select_in <= 1'b1;
  endtask : mode_test

  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_values();
    gate_test();
    select_test();
    count_shortest();
    count_stop_release();
    mode_test();
    print_verdict();
  end

endmodule : osc_stab_gate_bench
